/* core/pse_pkg.sv */
// Constants, register map and state codes for the step execution controller
package pse_pkg;
  // ==========================================================
  // Register map (word index on the plain register port)
  localparam logic [3:0] PSE_OFF_ENABLE = 4'h0;
  localparam logic [3:0] PSE_OFF_MODE = 4'h1;
  localparam logic [3:0] PSE_OFF_RESUME = 4'h2;
  localparam logic [3:0] PSE_OFF_START_NO = 4'h3;
  localparam logic [3:0] PSE_OFF_CMD = 4'h4;
  localparam logic [3:0] PSE_OFF_STATE = 4'h5;
  localparam logic [3:0] PSE_OFF_IRQ_STATUS = 4'h6;
  localparam logic [3:0] PSE_OFF_IRQ_MASK = 4'h7;
  // ==========================================================
  // Field positions and values
  localparam int PSE_CMD_START_BIT = 0;
  localparam int PSE_IRQ_INVALID_BIT = 0;
  localparam int PSE_IRQ_BUSY_BIT = 1;
  localparam int PSE_IRQ_STOP_BIT = 2;
  localparam int PSE_IRQ_W = 3;
  localparam logic PSE_MODE_DECEL_UNIT = 1'b0;
  localparam logic PSE_MODE_DATA_UNIT = 1'b1;
  localparam logic [1:0] PSE_REQ_NONE = 2'h0;
  localparam logic [1:0] PSE_REQ_CONTINUE = 2'h1;
  localparam logic [1:0] PSE_REQ_RESTART = 2'h2;
  // ==========================================================
  // Reset values
  localparam logic PSE_RST_ENABLE = 1'b0;
  localparam logic PSE_RST_MODE = 1'b0;
  localparam logic [1:0] PSE_RST_RESUME = 2'h0;
  localparam logic [15:0] PSE_RST_START_NO = 16'h0001;
  localparam logic [2:0] PSE_RST_IRQ_MASK = 3'h0;
  // ==========================================================
  // Axis operation state codes
  typedef enum logic [4:0] {
    PSE_ST_STANDING_BY = 5'h00,
    PSE_ST_STOPPED = 5'h01,
    PSE_ST_INTERP = 5'h02,
    PSE_ST_JOG = 5'h03,
    PSE_ST_MPG = 5'h04,
    PSE_ST_ANALYZING = 5'h05,
    PSE_ST_WAIT_SPECIAL = 5'h06,
    PSE_ST_ZERO_RETURN = 5'h07,
    PSE_ST_POS_CTRL = 5'h08,
    PSE_ST_SPEED_CTRL = 5'h09,
    PSE_ST_CHG_SPEED = 5'h0a,
    PSE_ST_CHG_POS = 5'h0b,
    PSE_ST_ERROR = 5'h0c,
    PSE_ST_SERVO_UNCONN = 5'h0d,
    PSE_ST_SERVO_OFF = 5'h0e,
    PSE_ST_STEP_STANDBY = 5'h0f,
    PSE_ST_STEP_STOPPED = 5'h10,
    PSE_ST_STEP_ERROR = 5'h11
  } pse_axis_state_e;
  // Control type of the positioning entry being executed
  typedef enum logic [3:0] {
    PSE_CT_MACHINE_ZERO = 4'h0,
    PSE_CT_FAST_ZERO = 4'h1,
    PSE_CT_LINEAR1 = 4'h2,
    PSE_CT_LINEAR2 = 4'h3,
    PSE_CT_FIXED1 = 4'h4,
    PSE_CT_FIXED2 = 4'h5,
    PSE_CT_CIRCULAR = 4'h6,
    PSE_CT_SPEED = 4'h7,
    PSE_CT_SPD_POS = 4'h8,
    PSE_CT_CUR_CHANGE = 4'h9,
    PSE_CT_JUMP = 4'ha,
    PSE_CT_JOG = 4'hb,
    PSE_CT_MPG = 4'hc
  } pse_ctrl_type_e;
  // Step sequencing phase
  typedef enum logic [2:0] {
    PSE_PH_NORMAL = 3'b000,
    PSE_PH_STEP = 3'b001,
    PSE_PH_STANDBY = 3'b010,
    PSE_PH_STOPPED = 3'b011,
    PSE_PH_ERROR = 3'b100
  } pse_phase_e;
endpackage : pse_pkg

/* core/pse_evt_if.sv */
// Event carrier from the step controller to its interrupt block
`timescale 1ns/1ps
`default_nettype none
interface pse_evt_if;
  logic warn_invalid;
  logic warn_busy;
  logic step_stop;
  modport src (output warn_invalid, output warn_busy, output step_stop);
  modport snk (input warn_invalid, input warn_busy, input step_stop);
endinterface : pse_evt_if
`default_nettype wire

/* core/pse_classify.sv */
// Step permission and resume request decision table
`timescale 1ns/1ps
`default_nettype none
module pse_classify (
  input wire pse_pkg::pse_ctrl_type_e ctrl_type,
  input wire pse_pkg::pse_axis_state_e state,
  input wire logic [1:0] req,
  input wire logic enable,
  output logic permit,
  output logic do_next,
  output logic do_resume,
  output logic warn_invalid,
  output logic warn_busy
);
  import pse_pkg::*;
  // ==========================================================
  // Which control types may be stepped
  always_comb begin
    unique case (ctrl_type)
      PSE_CT_LINEAR1, PSE_CT_LINEAR2, PSE_CT_FIXED1, PSE_CT_FIXED2,
      PSE_CT_CIRCULAR, PSE_CT_SPD_POS, PSE_CT_CUR_CHANGE,
      PSE_CT_JUMP: permit = 1'b1;
      default: permit = 1'b0;
    endcase
  end
  // ==========================================================
  // Resume request against the reported axis state
  always_comb begin
    logic valid_req;
    valid_req = (req == PSE_REQ_CONTINUE) || (req == PSE_REQ_RESTART);
    do_next = 1'b0;
    do_resume = 1'b0;
    warn_invalid = 1'b0;
    warn_busy = 1'b0;
    // Nothing at all happens unless stepping is switched on
    if (valid_req && enable) begin
      unique case (state)
        PSE_ST_STEP_STANDBY: begin
          do_next = (req == PSE_REQ_CONTINUE);
          warn_invalid = (req == PSE_REQ_RESTART);
        end
        PSE_ST_STEP_STOPPED: do_resume = 1'b1;
        PSE_ST_STEP_ERROR: warn_invalid = 1'b1;
        PSE_ST_STANDING_BY, PSE_ST_STOPPED, PSE_ST_ERROR,
        PSE_ST_SERVO_UNCONN, PSE_ST_SERVO_OFF, PSE_ST_INTERP,
        PSE_ST_JOG, PSE_ST_MPG: warn_invalid = 1'b1;
        PSE_ST_ANALYZING, PSE_ST_WAIT_SPECIAL, PSE_ST_ZERO_RETURN,
        PSE_ST_POS_CTRL, PSE_ST_SPEED_CTRL, PSE_ST_CHG_SPEED,
        PSE_ST_CHG_POS: warn_busy = 1'b1;
        default: warn_invalid = 1'b1;
      endcase
    end
  end
endmodule : pse_classify
`default_nettype wire

/* core/pse_irq.sv */
// Sticky event status with mask, read-to-clear, one level interrupt
`timescale 1ns/1ps
`default_nettype none
module pse_irq (
  input wire logic clock,
  input wire logic rst_n,
  pse_evt_if.snk evt,
  input wire logic mask_wr,
  input wire logic [2:0] mask_wdata,
  input wire logic status_rd,
  output logic [2:0] status,
  output logic [2:0] mask,
  output logic irq
);
  import pse_pkg::*;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic [2:0] set_vec;
  // ==========================================================
  // Status and mask
  always_comb begin
    set_vec = '0;
    set_vec[PSE_IRQ_INVALID_BIT] = evt.warn_invalid;
    set_vec[PSE_IRQ_BUSY_BIT] = evt.warn_busy;
    set_vec[PSE_IRQ_STOP_BIT] = evt.step_stop;
    // An event landing on the clearing read survives it
    status_next = (status_rd ? 3'h0 : status_reg) | set_vec;
    mask_next = mask_wr ? mask_wdata : mask_reg;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 3'h0;
      mask_reg <= PSE_RST_IRQ_MASK;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end
  assign status = status_reg;
  assign mask = mask_reg;
  assign irq = |(status_reg & mask_reg);
endmodule : pse_irq
`default_nettype wire

/* core/pse_step_ctrl.sv */
// Step execution controller for one positioning axis
`timescale 1ns/1ps
`default_nettype none
module pse_step_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire pse_pkg::pse_axis_state_e eng_status,
  input wire pse_pkg::pse_ctrl_type_e eng_ctrl_type,
  input wire logic eng_entry_done,
  input wire logic eng_entry_decel,
  input wire logic eng_stop_halt,
  input wire logic eng_error_halt,
  output logic pos_start,
  output logic [15:0] pos_start_no,
  output logic pos_next,
  output logic pos_resume,
  output logic stop_after_entry,
  output logic irq
);
  import pse_pkg::*;

  // ==========================================================
  // Declarations
  logic enable_reg;
  logic enable_next;
  logic mode_reg;
  logic mode_next;
  logic [1:0] resume_reg;
  logic [1:0] resume_next;
  logic [15:0] start_no_reg;
  logic [15:0] start_no_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  pse_phase_e phase_reg;
  pse_phase_e phase_next;
  logic start_reg;
  logic start_next;
  logic [15:0] start_no_out_reg;
  logic [15:0] start_no_out_next;
  logic next_reg;
  logic next_next;
  logic resume_out_reg;
  logic resume_out_next;
  pse_axis_state_e state_rep;
  logic wr_enable;
  logic wr_mode;
  logic wr_resume;
  logic wr_start_no;
  logic wr_cmd;
  logic wr_mask;
  logic rd_status;
  logic start_cmd;
  logic permit;
  logic do_next;
  logic do_resume;
  logic warn_invalid;
  logic warn_busy;
  logic stepping;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  pse_evt_if evt ();

  // ==========================================================
  // Register port decode
  always_comb begin
    wr_enable = reg_wr && (reg_addr == PSE_OFF_ENABLE);
    wr_mode = reg_wr && (reg_addr == PSE_OFF_MODE);
    wr_resume = reg_wr && (reg_addr == PSE_OFF_RESUME);
    wr_start_no = reg_wr && (reg_addr == PSE_OFF_START_NO);
    wr_cmd = reg_wr && (reg_addr == PSE_OFF_CMD);
    wr_mask = reg_wr && (reg_addr == PSE_OFF_IRQ_MASK);
    rd_status = reg_rd && (reg_addr == PSE_OFF_IRQ_STATUS);
    start_cmd = wr_cmd && reg_wdata[PSE_CMD_START_BIT];
  end

  // ==========================================================
  // Software settings
  always_comb begin
    enable_next = wr_enable ? reg_wdata[0] : enable_reg;
    // Bit 0 alone picks the stop point, so only two modes exist
    mode_next = wr_mode ? reg_wdata[0] : mode_reg;
    resume_next = wr_resume ? reg_wdata[1:0] : resume_reg;
    start_no_next = wr_start_no ? reg_wdata : start_no_reg;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= PSE_RST_ENABLE;
      mode_reg <= PSE_RST_MODE;
      resume_reg <= PSE_RST_RESUME;
      start_no_reg <= PSE_RST_START_NO;
    end else begin
      enable_reg <= enable_next;
      mode_reg <= mode_next;
      resume_reg <= resume_next;
      start_no_reg <= start_no_next;
    end
  end

  // ==========================================================
  // Reported axis operation state
  always_comb begin
    unique case (phase_reg)
      PSE_PH_STANDBY: state_rep = PSE_ST_STEP_STANDBY;
      PSE_PH_STOPPED: state_rep = PSE_ST_STEP_STOPPED;
      PSE_PH_ERROR: state_rep = PSE_ST_STEP_ERROR;
      default: state_rep = eng_status;
    endcase
  end

  // ==========================================================
  // Request evaluation
  // The request is judged against the state as it stands in the
  // cycle of the write, so the write itself is the trigger.
  pse_classify u_classify (
    .ctrl_type(eng_ctrl_type),
    .state(state_rep),
    .req(wr_resume ? reg_wdata[1:0] : PSE_REQ_NONE),
    .enable(enable_reg),
    .permit(permit),
    .do_next(do_next),
    .do_resume(do_resume),
    .warn_invalid(warn_invalid),
    .warn_busy(warn_busy)
  );

  // ==========================================================
  // Stop point selection
  // Combinational so the engine sees the choice in the very cycle
  // it finishes an entry; it may not wait for a register stage.
  always_comb begin
    stepping = enable_reg && (phase_reg == PSE_PH_STEP) && permit;
    if (!stepping) begin
      stop_after_entry = 1'b0;
    end else if (mode_reg == PSE_MODE_DATA_UNIT) begin
      // Overrides continuous path chaining
      stop_after_entry = 1'b1;
    end else begin
      stop_after_entry = eng_entry_decel;
    end
  end

  // ==========================================================
  // Step phase sequencing and engine commands
  always_comb begin
    phase_next = phase_reg;
    start_next = 1'b0;
    start_no_out_next = start_no_out_reg;
    next_next = 1'b0;
    resume_out_next = 1'b0;
    if (start_cmd) begin
      // A fresh start wins over every pending step state
      start_next = 1'b1;
      start_no_out_next = start_no_reg;
      phase_next = enable_reg ? PSE_PH_STEP : PSE_PH_NORMAL;
    end else if (!enable_reg) begin
      phase_next = PSE_PH_NORMAL;
    end else if (do_next) begin
      next_next = 1'b1;
      phase_next = PSE_PH_STEP;
    end else if (do_resume) begin
      resume_out_next = 1'b1;
      phase_next = PSE_PH_STEP;
    end else if (phase_reg == PSE_PH_STEP) begin
      if (eng_error_halt) begin
        phase_next = PSE_PH_ERROR;
      end else if (eng_stop_halt) begin
        phase_next = PSE_PH_STOPPED;
      end else if (eng_entry_done && stop_after_entry) begin
        phase_next = PSE_PH_STANDBY;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PSE_PH_NORMAL;
      start_reg <= 1'b0;
      start_no_out_reg <= PSE_RST_START_NO;
      next_reg <= 1'b0;
      resume_out_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      start_reg <= start_next;
      start_no_out_reg <= start_no_out_next;
      next_reg <= next_next;
      resume_out_reg <= resume_out_next;
    end
  end

  assign pos_start = start_reg;
  assign pos_start_no = start_no_out_reg;
  assign pos_next = next_reg;
  assign pos_resume = resume_out_reg;

  // ==========================================================
  // Events and interrupt
  assign evt.warn_invalid = warn_invalid;
  assign evt.warn_busy = warn_busy;
  assign evt.step_stop = (phase_reg == PSE_PH_STEP) &&
    (phase_next != PSE_PH_STEP) && (phase_next != PSE_PH_NORMAL);

  pse_irq u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .evt(evt),
    .mask_wr(wr_mask),
    .mask_wdata(reg_wdata[2:0]),
    .status_rd(rd_status),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // ==========================================================
  // Read data, valid in the cycle after the read strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        PSE_OFF_ENABLE: rdata_next = {15'h0000, enable_reg};
        PSE_OFF_MODE: rdata_next = {15'h0000, mode_reg};
        PSE_OFF_RESUME: rdata_next = {14'h0000, resume_reg};
        PSE_OFF_START_NO: rdata_next = start_no_reg;
        PSE_OFF_STATE: rdata_next = {11'h000, state_rep};
        PSE_OFF_IRQ_STATUS: rdata_next = {13'h0000, irq_status};
        PSE_OFF_IRQ_MASK: rdata_next = {13'h0000, irq_mask};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : pse_step_ctrl
`default_nettype wire

/* bench/pse_step_ctrl_monitor.sv */
// Port level checks for the step execution controller
`timescale 1ns/1ps
`default_nettype none
module pse_step_ctrl_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire pse_pkg::pse_ctrl_type_e eng_ctrl_type,
  input wire logic eng_entry_done,
  input wire logic eng_entry_decel,
  input wire logic pos_start,
  input wire logic [15:0] pos_start_no,
  input wire logic pos_next,
  input wire logic pos_resume,
  input wire logic stop_after_entry,
  input wire logic irq
);
  import pse_pkg::*;
  logic en_reg;
  logic mode_reg;
  logic [2:0] mask_reg;
  logic [15:0] sn_reg;
  logic start_wr;
  logic req_wr;
  logic fixed_type;
  assign start_wr = reg_wr && reg_addr == PSE_OFF_CMD && reg_wdata[0];
  assign req_wr = reg_wr && reg_addr == PSE_OFF_RESUME;
  assign fixed_type = eng_ctrl_type inside {PSE_CT_MACHINE_ZERO,
    PSE_CT_FAST_ZERO, PSE_CT_SPEED, PSE_CT_JOG, PSE_CT_MPG};
  // ==========================================================
  // Shadow of the host settings that the outputs depend on
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= PSE_RST_ENABLE;
      mode_reg <= PSE_RST_MODE;
      mask_reg <= PSE_RST_IRQ_MASK;
      sn_reg <= PSE_RST_START_NO;
    end else if (reg_wr) begin
      case (reg_addr)
        PSE_OFF_ENABLE: en_reg <= reg_wdata[0];
        PSE_OFF_MODE: mode_reg <= reg_wdata[0];
        PSE_OFF_IRQ_MASK: mask_reg <= reg_wdata[2:0];
        PSE_OFF_START_NO: sn_reg <= reg_wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions
  a_start_pulse: assert property (start_wr |=> pos_start &&
    pos_start_no == sn_reg) else $error("start not passed on");
  a_start_cause: assert property (pos_start |-> $past(start_wr))
    else $error("start without command");
  a_next_cause: assert property (pos_next |-> $past(req_wr && en_reg &&
    reg_wdata[1:0] == PSE_REQ_CONTINUE)) else $error("stray next");
  a_resume_cause: assert property (pos_resume |-> $past(req_wr &&
    en_reg && reg_wdata[1:0] inside {2'h1, 2'h2}))
    else $error("stray resume");
  a_off_quiet: assert property (req_wr && !en_reg |=>
    !pos_next && !pos_resume) else $error("request acted while off");
  a_fixed_run: assert property (fixed_type |-> !stop_after_entry)
    else $error("step stop on fixed type");
  a_stop_enable: assert property (stop_after_entry |-> en_reg)
    else $error("step stop while disabled");
  a_decel_unit: assert property (stop_after_entry &&
    mode_reg == PSE_MODE_DECEL_UNIT |-> eng_entry_decel)
    else $error("decel unit stop without decel");
  a_stop_irq: assert property (eng_entry_done && stop_after_entry &&
    mask_reg[PSE_IRQ_STOP_BIT] |=> irq) else $error("no stop interrupt");
endmodule : pse_step_ctrl_monitor
`default_nettype wire

/* bench/pse_engine_model.sv */
// Behavioural positioning engine facing the step controller
`timescale 1ns/1ps
`default_nettype none
module pse_engine_model #(
  parameter int LEN = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pos_start,
  input wire logic pos_next,
  input wire logic pos_resume,
  input wire logic stop_after_entry,
  input wire pse_pkg::pse_ctrl_type_e type_in,
  input wire logic decel_in,
  input wire logic [1:0] halt_in,
  input wire pse_pkg::pse_axis_state_e idle_st,
  output var pse_pkg::pse_axis_state_e eng_status,
  output var pse_pkg::pse_ctrl_type_e eng_ctrl_type,
  output logic eng_entry_done,
  output logic eng_entry_decel,
  output logic eng_stop_halt,
  output logic eng_error_halt
);
  import pse_pkg::*;
  logic busy;
  logic [7:0] cnt;
  logic fin;
  // Entries chain until the controller asks for a stop or a halt is set
  assign fin = busy && cnt == 8'(LEN);
  assign eng_status = busy ? PSE_ST_POS_CTRL : idle_st;
  assign eng_ctrl_type = type_in;
  assign eng_entry_decel = decel_in;
  assign eng_entry_done = fin && halt_in == 2'h0;
  assign eng_stop_halt = fin && halt_in == 2'h1;
  assign eng_error_halt = fin && halt_in == 2'h2;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (pos_start || pos_next || pos_resume) begin
      busy <= 1'b1;
      cnt <= 8'h00;
    end else if (fin) begin
      busy <= !(halt_in != 2'h0 || stop_after_entry);
      cnt <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : pse_engine_model
`default_nettype wire

/* bench/pse_step_ctrl_tb_top.sv */
// Top testbench for the step execution controller
`timescale 1ns/1ps
`default_nettype none
module pse_step_ctrl_tb_top;
  import pse_pkg::*;
  localparam int LEN = 6;
  logic clock, rst_n, reg_wr, reg_rd, decel_in, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pos_start_no, last_no;
  logic pos_start, pos_next, pos_resume, stop_after_entry;
  logic eng_entry_done, eng_entry_decel, eng_stop_halt, eng_error_halt;
  logic [1:0] halt_in;
  pse_axis_state_e eng_status, idle_st;
  pse_ctrl_type_e eng_ctrl_type, type_in;
  int n_errors, comparisons, n_start, n_next, n_res;
  pse_step_ctrl pse_step_ctrl_inst (.clock, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .eng_status, .eng_ctrl_type,
    .eng_entry_done, .eng_entry_decel, .eng_stop_halt, .eng_error_halt,
    .pos_start, .pos_start_no, .pos_next, .pos_resume, .stop_after_entry,
    .irq);
  pse_engine_model #(.LEN(LEN)) pse_engine_model_inst (.clock, .rst_n,
    .pos_start, .pos_next, .pos_resume, .stop_after_entry, .type_in,
    .decel_in, .halt_in, .idle_st, .eng_status, .eng_ctrl_type,
    .eng_entry_done, .eng_entry_decel, .eng_stop_halt, .eng_error_halt);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    n_next += int'(pos_next === 1'b1);
    n_res += int'(pos_resume === 1'b1);
    if (pos_start === 1'b1) begin
      n_start++;
      last_no = pos_start_no;
    end
  end
  // ==========================================================
  // Register port tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  // Model timing is ours, so fixed waits cover one entry with margin
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt
  task automatic end_of_test();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  // ==========================================================
  // Test sequence
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, decel_in, halt_in} = '0;
    idle_st = PSE_ST_STANDING_BY;
    type_in = PSE_CT_LINEAR1;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++)
      if (a != 4) rd(4'(a), a == 3 ? 16'h0001 : 16'h0000);
    wr(PSE_OFF_STATE, 16'h001f);
    rd(PSE_OFF_STATE, 16'h0000);
    wr(PSE_OFF_RESUME, 16'h0001);
    rd(PSE_OFF_IRQ_STATUS, 16'h0000);
    wr(PSE_OFF_ENABLE, 16'h0001);
    wr(PSE_OFF_RESUME, 16'h0002);
    chk({15'h0, irq}, 16'h0000);
    wr(PSE_OFF_IRQ_MASK, 16'h0007);
    for (int c = 0; c < 15; c++) begin
      idle_st = pse_axis_state_e'(c);
      wr(PSE_OFF_RESUME, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd(PSE_OFF_IRQ_STATUS, (c > 4 && c < 12) ? 16'h2 : 16'h1);
    end
    idle_st = PSE_ST_STANDING_BY;
    chk(16'(n_next + n_res), 16'h0000);
    wr(PSE_OFF_MODE, 16'h0001);
    for (int t = 0; t < 13; t++) begin
      type_in = pse_ctrl_type_e'(t);
      wr(PSE_OFF_START_NO, 16'(t + 16));
      wr(PSE_OFF_CMD, 16'h0001);
      wt(LEN + 4);
      chk(last_no, 16'(t + 16));
      if (t inside {0, 1, 7, 11, 12}) begin
        rd(PSE_OFF_STATE, 16'(PSE_ST_POS_CTRL));
        halt_in = 2'h1;
        wt(LEN + 3);
        halt_in = 2'h0;
        rd(PSE_OFF_STATE, 16'(PSE_ST_STEP_STOPPED));
        wr(PSE_OFF_RESUME, {15'h0, t[0]} + 16'h1);
      end else rd(PSE_OFF_STATE, 16'(PSE_ST_STEP_STANDBY));
    end
    // The last resume pulse is only counted at the next edge
    wt(1);
    chk(16'(n_res), 16'h0005);
    halt_in = 2'h1;
    wt(LEN + 3);
    halt_in = 2'h0;
    type_in = PSE_CT_LINEAR1;
    rd(PSE_OFF_IRQ_STATUS, 16'h0004);
    wr(PSE_OFF_CMD, 16'h0001);
    wt(LEN + 4);
    rd(PSE_OFF_STATE, 16'(PSE_ST_STEP_STANDBY));
    wr(PSE_OFF_RESUME, 16'h0002);
    rd(PSE_OFF_IRQ_STATUS, 16'h0005);
    chk(16'(n_next), 16'h0000);
    // Request code 3 is neither continue nor restart: stored, ignored
    wr(PSE_OFF_RESUME, 16'h0003);
    rd(PSE_OFF_IRQ_STATUS, 16'h0000);
    wr(PSE_OFF_RESUME, 16'h0001);
    wt(1);
    chk(16'(n_next), 16'h0001);
    halt_in = 2'h2;
    wt(LEN + 3);
    halt_in = 2'h0;
    rd(PSE_OFF_STATE, 16'(PSE_ST_STEP_ERROR));
    rd(PSE_OFF_IRQ_STATUS, 16'h0004);
    wr(PSE_OFF_RESUME, 16'h0001);
    wr(PSE_OFF_RESUME, 16'h0002);
    rd(PSE_OFF_IRQ_STATUS, 16'h0001);
    chk(16'(n_next + n_res), 16'h0006);
    wr(PSE_OFF_MODE, 16'h0000);
    wr(PSE_OFF_CMD, 16'h0001);
    wt(LEN + 4);
    rd(PSE_OFF_STATE, 16'(PSE_ST_POS_CTRL));
    decel_in = 1'b1;
    wt(LEN + 4);
    rd(PSE_OFF_STATE, 16'(PSE_ST_STEP_STANDBY));
    wr(PSE_OFF_ENABLE, 16'h0000);
    wr(PSE_OFF_CMD, 16'h0001);
    wt(LEN + 4);
    rd(PSE_OFF_STATE, 16'(PSE_ST_POS_CTRL));
    halt_in = 2'h1;
    wt(LEN + 3);
    rd(PSE_OFF_STATE, 16'(PSE_ST_STANDING_BY));
    // A command word with the start bit clear must not start anything
    wr(PSE_OFF_CMD, 16'h0000);
    wt(2);
    chk(16'(n_start), 16'h0010);
    end_of_test();
  end
endmodule : pse_step_ctrl_tb_top
bind pse_step_ctrl pse_step_ctrl_monitor pse_step_ctrl_monitor_inst (
  .clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .eng_ctrl_type,
  .eng_entry_done, .eng_entry_decel, .pos_start, .pos_start_no, .pos_next,
  .pos_resume, .stop_after_entry, .irq);
`default_nettype wire
